// ==== core/sirse_pkg.sv ====
// Package for the SMBus information ROM and scratch EEPROM slave.
// Assumes a single slave address and byte-wide command and data.
package sirse_pkg;
    localparam logic [7:0] OFF_BLOCK_A_CSUM = 8'h73;
    localparam logic [7:0] OFF_CORE_FLAGS = 8'h74;
    localparam logic [7:0] OFF_PKG_FLAGS = 8'h78;
    localparam logic [7:0] OFF_EXTRA_FLAGS = 8'h79;
    localparam logic [7:0] OFF_PAD_BYTE = 8'h7c;
    localparam logic [7:0] OFF_BLOCK_B_CSUM = 8'h7d;
    localparam logic [7:0] OFF_TAIL_PAD = 8'h7e;
    localparam int REGION_BIT = 7;
    localparam int FLAG_SERIAL_SIG = 6;
    localparam int FLAG_ELEC_SIG = 5;
    localparam int FLAG_THERM_SENSE = 4;
    localparam int FLAG_OEM_EEPROM = 2;
    localparam int FLAG_CORE_VID = 1;
    localparam logic [7:0] PKG_FLAGS_RSVD_MASK = 8'h89;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h50;
    localparam int WRITE_TIME_MS = 10;

    typedef enum logic [2:0] {
        SIRSE_IDLE = 3'b000,
        SIRSE_ADDR = 3'b001,
        SIRSE_ACK = 3'b010,
        SIRSE_RXB = 3'b011,
        SIRSE_TXB = 3'b100,
        SIRSE_TXACK = 3'b101
    } sirse_state_t;

    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } sirse_wreq_t;
endpackage : sirse_pkg

// ==== core/sirse_top.sv ====
// SMBus slave fronting a 256-byte component: information ROM below, scratch EEPROM above.
// Assumes scl/sda arrive as pin inputs with enables resolved by the bench; sda output
// enable is low while the slave pulls the line low. The link logic runs on linkClk.
// Function
// RULE1 - ROM bytes 74h-77h return core feature word
// RULE2 - Byte 78h holds package feature flag bits
// RULE3 - Protect pin high blocks scratch writes
// RULE4 - Undriven protect pin reads as writable
// RULE5 - Scratch EEPROM occupies 80h through FFh
// RULE6 - ROM occupies 00h-7Fh, never writable
// RULE7 - ROM write acknowledged, data discarded
// RULE8 - Read Byte and Write Byte answered
// RULE9 - Host waits 10 ms after scratch write
// RULE10 - Command top bit selects memory half
// RULE11 - Read Byte sequence with repeated start
// RULE12 - Write Byte acknowledged after each byte
// RULE13 - Protected scratch write still acknowledged
`timescale 1ns/1ps
module sirse_top #(
    parameter logic [6:0] SLAVE_ADDR = sirse_pkg::DEFAULT_SLAVE_ADDR,
    parameter logic [31:0] CORE_FLAGS = 32'h0000_0000,
    parameter logic [7:0] PKG_FLAGS = 8'h00,
    parameter logic [7:0] BLOCK_A_CSUM = 8'h00,
    parameter logic [7:0] BLOCK_B_CSUM = 8'h00,
    parameter logic [1023:0] ROM_LOW = '0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic linkClk,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOutEn,
    input wire logic eeprom_write_protect_in,
    output logic writeDone
);
    // Link domain: scl and sda are sampled on linkClk through two flops
    logic [1:0] sclSync_r;
    logic [1:0] sdaSync_r;
    // Protect pin is asynchronous to the link clock as well
    logic [1:0] wpSync_r;
    logic sclPrev_r;
    logic sdaPrev_r;
    sirse_pkg::sirse_state_t state_r;
    logic [3:0] bitCnt_r;
    logic [7:0] shift_r;
    logic [1:0] byteIdx_r;
    logic isRead_r;
    logic [7:0] cmd_r;
    logic [7:0] txByte_r;
    logic sdaOut_r;
    logic wrToggle_r;
    logic [7:0] wrAddr_r;
    logic [7:0] wrData_r;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic addrMatch;

    // Byte store, written in the system domain and read in the link domain through the registered command address
    logic [7:0] scratch [0:127];
    logic [7:0] rdData;
    logic [7:0] romByte;

    function automatic logic [7:0] romLookup(input logic [6:0] a);
        logic [7:0] v;
        v = ROM_LOW[{a, 3'b000} +: 8];
        unique case ({1'b0, a})
            sirse_pkg::OFF_BLOCK_A_CSUM: v = BLOCK_A_CSUM;
            sirse_pkg::OFF_CORE_FLAGS: v = CORE_FLAGS[7:0]; // RULE1
            8'h75: v = CORE_FLAGS[15:8]; // RULE1
            8'h76: v = CORE_FLAGS[23:16]; // RULE1
            8'h77: v = CORE_FLAGS[31:24]; // RULE1
            sirse_pkg::OFF_PKG_FLAGS: v = PKG_FLAGS & ~sirse_pkg::PKG_FLAGS_RSVD_MASK; // RULE2
            sirse_pkg::OFF_BLOCK_B_CSUM: v = BLOCK_B_CSUM;
            8'h79, 8'h7a, 8'h7b, sirse_pkg::OFF_PAD_BYTE, sirse_pkg::OFF_TAIL_PAD, 8'h7f:
                v = sirse_pkg::RESET_BYTE;
            default: v = ROM_LOW[{a, 3'b000} +: 8];
        endcase
        return v;
    endfunction : romLookup

    assign sclRise = sclSync_r[1] & ~sclPrev_r;
    assign sclFall = ~sclSync_r[1] & sclPrev_r;
    assign startCond = sclSync_r[1] & sclPrev_r & sdaPrev_r & ~sdaSync_r[1];
    assign stopCond = sclSync_r[1] & sclPrev_r & ~sdaPrev_r & sdaSync_r[1];
    assign addrMatch = (shift_r[7:1] == SLAVE_ADDR);
    assign romByte = romLookup(cmd_r[6:0]);
    // RULE10 RULE5 RULE6
    assign rdData = cmd_r[sirse_pkg::REGION_BIT] ? scratch[cmd_r[6:0]] : romByte;

    always_ff @(posedge linkClk or negedge resetn) begin
        if (!resetn) begin
            sclSync_r <= 2'b11;
            sdaSync_r <= 2'b11;
            wpSync_r <= 2'b00;
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
        end else begin
            sclSync_r <= {sclSync_r[0], scl};
            sdaSync_r <= {sdaSync_r[0], sdaIn};
            wpSync_r <= {wpSync_r[0], eeprom_write_protect_in}; // RULE3
            sclPrev_r <= sclSync_r[1];
            sdaPrev_r <= sdaSync_r[1];
        end
    end

    // Byte-level slave; a start anywhere restarts framing, which gives the repeated start
    always_ff @(posedge linkClk or negedge resetn) begin
        if (!resetn) begin
            state_r <= sirse_pkg::SIRSE_IDLE;
            bitCnt_r <= 4'h0;
            shift_r <= 8'h00;
            byteIdx_r <= 2'b00;
            isRead_r <= 1'b0;
            cmd_r <= 8'h00;
            txByte_r <= 8'h00;
            sdaOut_r <= 1'b1;
            wrToggle_r <= 1'b0;
            wrAddr_r <= 8'h00;
            wrData_r <= 8'h00;
        end else if (startCond) begin
            state_r <= sirse_pkg::SIRSE_ADDR; // RULE11
            bitCnt_r <= 4'h0;
            byteIdx_r <= 2'b00;
            sdaOut_r <= 1'b1;
        end else if (stopCond) begin
            state_r <= sirse_pkg::SIRSE_IDLE;
            sdaOut_r <= 1'b1;
        end else begin
            unique case (state_r)
                sirse_pkg::SIRSE_IDLE: sdaOut_r <= 1'b1;
                sirse_pkg::SIRSE_ADDR, sirse_pkg::SIRSE_RXB: begin
                    if (sclRise) begin
                        shift_r <= {shift_r[6:0], sdaSync_r[1]};
                        bitCnt_r <= 4'(bitCnt_r + 4'h1);
                    end else if (sclFall && bitCnt_r == 4'h8) begin
                        bitCnt_r <= 4'h0;
                        if (state_r == sirse_pkg::SIRSE_ADDR) begin
                            if (addrMatch) begin
                                isRead_r <= shift_r[0];
                                sdaOut_r <= 1'b0; // RULE8
                                state_r <= sirse_pkg::SIRSE_ACK;
                            end else begin
                                state_r <= sirse_pkg::SIRSE_IDLE;
                            end
                        end else if (byteIdx_r == 2'b00) begin
                            cmd_r <= shift_r; // RULE10
                            byteIdx_r <= 2'b01;
                            sdaOut_r <= 1'b0; // RULE12
                            state_r <= sirse_pkg::SIRSE_ACK;
                        end else begin
                            // ROM or protected scratch data is acknowledged and dropped
                            if (cmd_r[sirse_pkg::REGION_BIT] && !wpSync_r[1]) begin // RULE3 RULE4 RULE6 RULE7 RULE13
                                wrAddr_r <= cmd_r;
                                wrData_r <= shift_r;
                                wrToggle_r <= ~wrToggle_r;
                            end
                            byteIdx_r <= 2'b10;
                            sdaOut_r <= 1'b0; // RULE12
                            state_r <= sirse_pkg::SIRSE_ACK;
                        end
                    end
                end
                sirse_pkg::SIRSE_ACK: begin
                    if (sclFall) begin
                        if (isRead_r) begin
                            txByte_r <= {rdData[6:0], 1'b0};
                            sdaOut_r <= rdData[7]; // RULE11
                            bitCnt_r <= 4'h1;
                            state_r <= sirse_pkg::SIRSE_TXB;
                        end else begin
                            sdaOut_r <= 1'b1;
                            state_r <= sirse_pkg::SIRSE_RXB;
                        end
                    end
                end
                sirse_pkg::SIRSE_TXB: begin
                    if (sclFall) begin
                        if (bitCnt_r == 4'h8) begin
                            sdaOut_r <= 1'b1;
                            state_r <= sirse_pkg::SIRSE_TXACK;
                        end else begin
                            sdaOut_r <= txByte_r[7];
                            txByte_r <= {txByte_r[6:0], 1'b0};
                            bitCnt_r <= 4'(bitCnt_r + 4'h1);
                        end
                    end
                end
                sirse_pkg::SIRSE_TXACK: begin
                    // Host NACKs the single data byte; return to idle on the scl rise of that NACK
                    if (sclRise && sdaSync_r[1]) begin
                        state_r <= sirse_pkg::SIRSE_IDLE; // RULE11
                    end
                end
                default: state_r <= sirse_pkg::SIRSE_IDLE;
            endcase
        end
    end

    // System domain: write commit through a toggle; address and data are stable by then
    logic [2:0] wrTogSync_r;
    logic writeDone_r;
    logic wrEvent;
    logic [7:0] wrAddrSys;
    logic [7:0] wrDataSys;

    assign wrEvent = wrTogSync_r[2] ^ wrTogSync_r[1];
    assign wrAddrSys = wrAddr_r;
    assign wrDataSys = wrData_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrTogSync_r <= 3'b000;
            writeDone_r <= 1'b0;
        end else if (clkEn) begin
            wrTogSync_r <= {wrTogSync_r[1:0], wrToggle_r};
            writeDone_r <= wrEvent;
        end
    end

    // The host keeps a 10 ms gap after a scratch write, so no read races this store
    always_ff @(posedge clk) begin
        if (clkEn && wrEvent) begin
            scratch[wrAddrSys[6:0]] <= wrDataSys; // RULE5 RULE9
        end
    end

    assign sdaOut = 1'b0;

    always_ff @(posedge linkClk or negedge resetn) begin
        if (!resetn) begin
            sdaOutEn <= 1'b1;
        end else begin
            sdaOutEn <= sdaOut_r;
        end
    end

    assign writeDone = writeDone_r;
endmodule : sirse_top

// ==== tb/sirse_host.sv ====
// SMBus host controller model: drives scl, pulls sda low, reports each transfer.
// Assumes a pull-up on sda outside; paced by the system clock.
`timescale 1ns/1ps
module sirse_host (
    input wire logic clk,
    output logic scl,
    output logic pullLow,
    input wire logic sdaLine,
    output logic resVal,
    output logic [10:0] res
);
    localparam int HALF = 10;
    // Post-write gap cut well below 10 ms to keep the run short
    localparam int WR_GAP = 200;
    initial begin
        scl = 1'b1;
        pullLow = 1'b0;
        resVal = 1'b0;
        res = 11'h000;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic bitx(input logic b, output logic s);
        tick(1);
        pullLow <= ~b;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF / 2);
        s = sdaLine;
        tick(HALF / 2);
        scl <= 1'b0;
    endtask : bitx
    task automatic byteX(input logic [7:0] v, output logic [7:0] r, output logic a);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(v[i], s);
            r[i] = s;
        end
        bitx(1'b1, s);
        a = ~s;
    endtask : byteX
    // Raises sda before scl, so it also serves as repeated start
    task automatic startC();
        tick(1);
        pullLow <= 1'b0;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        pullLow <= 1'b1;
        tick(HALF);
        scl <= 1'b0;
    endtask : startC
    task automatic stopC();
        tick(1);
        pullLow <= 1'b1;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        pullLow <= 1'b0;
        tick(HALF);
    endtask : stopC
    task automatic xfer(input logic [6:0] sa, input logic rd, input logic [7:0] cmd,
        input logic [7:0] d);
        logic [7:0] r;
        logic [2:0] a;
        logic na;
        startC();
        byteX({sa, 1'b0}, r, a[2]);
        byteX(cmd, r, a[1]);
        if (rd) begin
            startC();
            byteX({sa, 1'b1}, r, a[0]);
            byteX(8'hff, r, na);
        end else begin
            byteX(d, r, a[0]);
        end
        stopC();
        res <= {a, r};
        resVal <= 1'b1;
        tick(1);
        resVal <= 1'b0;
        if (!rd) tick(WR_GAP);
    endtask : xfer
endmodule : sirse_host

// ==== tb/sirse_top_monitor.sv ====
// Checker for the slave's pins; bound to sirse_top.
// Assumes the host paces scl far slower than the link clock.
`timescale 1ns/1ps
module sirse_top_monitor (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic linkClk,
    input wire logic scl,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOutEn,
    input wire logic eeprom_write_protect_in,
    input wire logic writeDone
);
    chk_open_drain: assert property (@(posedge linkClk) disable iff (!resetn)
        sdaOut == 1'b0) else $error("sda output not low");
    chk_reset_idle: assert property (@(posedge clk)
        !resetn |-> sdaOutEn && !writeDone) else $error("outputs active in reset");
    chk_protect_hold: assert property (@(posedge clk) disable iff (!resetn)
        eeprom_write_protect_in && $past(eeprom_write_protect_in, 8) |-> !writeDone)
        else $error("commit while protected");
    chk_done_single: assert property (@(posedge clk) disable iff (!resetn)
        writeDone |=> !writeDone) else $error("commit pulse too long");
    chk_done_in_ack: assert property (@(posedge clk) disable iff (!resetn)
        writeDone |-> !sdaOutEn) else $error("commit outside data ack");
    chk_sda_scl_low: assert property (@(posedge linkClk) disable iff (!resetn)
        $changed(sdaOutEn) |-> !scl) else $error("sda moved while scl high");
    chk_ack_holds: assert property (@(posedge linkClk) disable iff (!resetn)
        $fell(sdaOutEn) |-> !sdaOutEn [*8]) else $error("ack too short");
    chk_ack_release: assert property (@(posedge clk) disable iff (!resetn)
        $fell(sdaOutEn) |-> ##[1:400] sdaOutEn) else $error("sda held too long");
    cov_commit: cover property (@(posedge clk) writeDone);
    cov_prot_ack: cover property (@(posedge clk) eeprom_write_protect_in && $fell(sdaOutEn));
    cov_release: cover property (@(posedge linkClk) $rose(sdaOutEn));
endmodule : sirse_top_monitor
bind sirse_top sirse_top_monitor i_sirse_top_monitor (.clk(clk), .resetn(resetn),
    .clkEn(clkEn), .linkClk(linkClk), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOutEn(sdaOutEn), .eeprom_write_protect_in(eeprom_write_protect_in),
    .writeDone(writeDone));

// ==== tb/test_smbus_info_rom_scratch_eeprom.sv ====
// Bench for the information ROM and scratch EEPROM slave.
// Assumes sirse_host as partner; sda has a pull-up, the protect pin a pull-down.
`timescale 1ns/1ps
module test_smbus_info_rom_scratch_eeprom;
    localparam logic [31:0] CORE = 32'h8a3c_51e7;
    logic clk = 1'b0;
    logic linkClk = 1'b0;
    logic resetn = 1'b0;
    logic clkEn = 1'b1;
    logic wpDrv = 1'bz;
    logic scl, pullLow, sdaOut, sdaOutEn, writeDone, resVal;
    logic [10:0] res;
    logic [10:0] expQ[$];
    logic [7:0] a, d;
    int err_total = 0;
    int n_tests = 0;
    int seed = 92129;
    int doneCnt = 0;
    wire sdaLine = ~pullLow & (sdaOutEn | sdaOut);
    wire wp;
    assign wp = wpDrv;
    pulldown (wp);
    always #10 clk = ~clk;
    always #3 linkClk = ~linkClk;
    sirse_top #(.CORE_FLAGS(CORE), .PKG_FLAGS(8'hff), .BLOCK_A_CSUM(8'h5a)) i_sirse_top (
        .clk(clk), .resetn(resetn), .clkEn(clkEn), .linkClk(linkClk), .scl(scl),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOutEn(sdaOutEn),
        .eeprom_write_protect_in(wp), .writeDone(writeDone));
    sirse_host i_sirse_host (.clk(clk), .scl(scl), .pullLow(pullLow), .sdaLine(sdaLine),
        .resVal(resVal), .res(res));
    task check(input logic [10:0] got, input logic [10:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task op(input logic rd, input logic [6:0] sa, input logic [7:0] c, input logic [7:0] v,
        input logic [2:0] ak);
        expQ.push_back({ak, v});
        i_sirse_host.xfer(sa, rd, c, v);
    endtask : op
    task conclude();
        $display("Mismatches %0d, comparisons %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    always @(posedge clk) begin
        if (writeDone === 1'b1) doneCnt <= doneCnt + 1;
        if (resVal === 1'b1) check(res, expQ.pop_front());
    end
    initial begin : watchdog
        repeat (60000) @(posedge clk);
        err_total++;
        $display("Error at %0t: watchdog expired", $time);
        conclude();
    end
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 4; i++) op(1, 7'h50, 8'h74 + 8'(i), CORE[8*i +: 8], 3'h7);
        op(1, 7'h50, 8'h78, 8'h76, 3'h7);
        op(1, 7'h50, 8'h7c, 8'h00, 3'h7);
        op(0, 7'h50, 8'h73, 8'ha5, 3'h7);
        op(1, 7'h50, 8'h73, 8'h5a, 3'h7);
        for (int k = 0; k < 3; k++) begin
            a = 8'h80 | 8'($random(seed));
            d = 8'($random(seed));
            wpDrv <= (k == 0) ? 1'bz : 1'b0;
            op(0, 7'h50, a, d, 3'h7);
            op(1, 7'h50, a, d, 3'h7);
        end
        wpDrv <= 1'b1;
        op(0, 7'h50, a, ~d, 3'h7);
        op(1, 7'h50, a, d, 3'h7);
        wpDrv <= 1'b0;
        op(0, 7'h51, 8'h81, d, 3'h0);
        repeat (20) @(posedge clk);
        check(11'(doneCnt), 11'h003);
        conclude();
    end
endmodule : test_smbus_info_rom_scratch_eeprom
